// ### sim/serial_tx_symbol_encoder_bench.sv
`timescale 1ns/100ps
module serial_tx_symbol_encoder_bench;
	import ste_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn, ce, fifo_bypass_n, encoder_bypass, char_width_select, tx_fifo_reset, tx_halt_input;
	logic        tx_load_enable, tx_special_select, tx_violation_send;
	logic [9:0]  tx_data_bus;
	logic [7:0]  tx_command_bus;
	logic        serial_out, reference_clock, char_strobe, prev_lvl;
	logic        want_load, want_special, want_viol;
	logic [9:0]  want_data;
	logic [7:0]  want_cmd;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          miscompares = 0;
	int          comparisons = 0;

	ste_encoder_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .fifo_bypass_n(fifo_bypass_n),
		.encoder_bypass(encoder_bypass), .char_width_select(char_width_select), .tx_fifo_reset(tx_fifo_reset),
		.tx_halt_input(tx_halt_input), .tx_load_enable(tx_load_enable), .tx_data_bus(tx_data_bus),
		.tx_command_bus(tx_command_bus), .tx_special_select(tx_special_select),
		.tx_violation_send(tx_violation_send), .serial_out(serial_out), .reference_clock(reference_clock),
		.char_strobe(char_strobe), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	ste_host_model u_host (.aclk(aclk), .aresetn(aresetn), .char_strobe(char_strobe), .want_load(want_load),
		.want_special(want_special), .want_viol(want_viol), .want_data(want_data), .want_cmd(want_cmd),
		.tx_load_enable(tx_load_enable), .tx_data_bus(tx_data_bus), .tx_command_bus(tx_command_bus),
		.tx_special_select(tx_special_select), .tx_violation_send(tx_violation_send));

	// 25 MHz clock
	always #20 aclk = ~aclk;
	// line level before each edge, for undoing the transition coding
	always @(posedge aclk) prev_lvl <= serial_out;

	task summarize();
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task timeout();
		miscompares++;
		summarize();
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// returns just after the edge that raised the capture mark
	task wait_strobe();
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while (char_strobe !== 1'b1 && n < 60);
		if (char_strobe !== 1'b1) timeout();
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	// one character through the host, then the decoded line bits of its slot
	task send(input logic ld, sp, vi, input logic [9:0] d, input logic [7:0] c, input logic [11:0] exp,
		input int nb);
		logic [11:0] got;
		int          i;
		got = 12'h000;
		wait_strobe();
		want_load = ld;
		want_special = sp;
		want_viol = vi;
		want_data = d;
		want_cmd = c;
		// captured one slot on, on the line the slot after
		wait_strobe();
		// a command goes out once, never as a repeated run
		want_special = 1'b0;
		wait_strobe();
		for (i = nb - 1; i >= 0; i--) begin
			got[i] = serial_out ^ prev_lvl;
			if (i > 0) begin
				@(posedge aclk);
				#1;
			end
		end
		cmp({20'h0, got}, {20'h0, exp});
	endtask

	task t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(OFS_CTRL, d, r);
		cmp(d, {30'h0, CTRL_RST});
		axi_rd(OFS_STATUS, d, r);
		cmp(d & 32'h7, 32'h4);
		axi_rd(8'h0C, d, r);
		cmp(d, 32'h0);
		cmp({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_wr(8'h0C, 32'h1, r);
		cmp({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_wr(OFS_STATUS, 32'hF, r);
		cmp({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task t_enc8();
		logic [3:0] k;
		for (int i = 0; i < 16; i++) begin
			k = 4'(i);
			send(1'b1, 1'b0, 1'b0, {2'b11, k, ~k}, 8'h00, {2'h0, SYM5[k], SYM5[~k]}, 10);
			send(1'b1, 1'b1, 1'b0, 10'h3FF, {4'hA, k}, {2'h0, CMD8[k]}, 10);
		end
		send(1'b1, 1'b0, 1'b1, 10'h055, 8'h00, {2'h0, VIOL_SYM5, VIOL_SYM5}, 10);
	endtask

	task t_fill8();
		logic [31:0] d0, d1;
		logic [1:0]  r;
		axi_rd(OFS_FILL, d0, r);
		send(1'b0, 1'b0, 1'b0, 10'h0A5, 8'h00, 12'h311, 10);
		axi_rd(OFS_FILL, d1, r);
		cmp({31'h0, d1 > d0}, 32'h1);
		// a write clears the fill count, at most one fill since
		axi_wr(OFS_FILL, 32'h0, r);
		cmp({30'h0, r}, {30'h0, RESP_OKAY});
		axi_rd(OFS_FILL, d0, r);
		cmp({31'h0, d0 < 32'h2}, 32'h1);
	endtask

	task t_ignore();
		@(posedge aclk);
		tx_fifo_reset <= 1'b1;
		tx_halt_input <= 1'b1;
		send(1'b1, 1'b0, 1'b0, 10'h0C3, 8'h00, {2'h0, SYM5[4'hC], SYM5[4'h3]}, 10);
		@(posedge aclk);
		encoder_bypass <= 1'b1;
		// raw character leaves lsb first, special select has no say
		send(1'b1, 1'b1, 1'b0, 10'h0C3, 8'h0F, 12'h30C, 10);
		@(posedge aclk);
		tx_fifo_reset <= 1'b0;
		tx_halt_input <= 1'b0;
		encoder_bypass <= 1'b0;
	endtask

	task t_enc10();
		logic [4:0] g;
		logic [4:0] h;
		logic [1:0] k;
		@(posedge aclk);
		char_width_select <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			g = 5'(i);
			h = ~g;
			send(1'b1, 1'b0, 1'b0, {h[4], g, h[3:0]}, 8'h00, {SYM6[g], SYM6[h]}, 12);
		end
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			send(1'b1, 1'b1, 1'b0, 10'h000, {k[1], 6'h2A, k[0]}, CMD10[k], 12);
		end
		send(1'b0, 1'b0, 1'b0, 10'h2AA, 8'h00, 12'h623, 12);
	endtask

	// times five: a 12-bit slot spans 24 clocks
	task t_rate();
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		axi_wr(OFS_CTRL, 32'h3, r);
		repeat (2) wait_strobe();
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while (char_strobe !== 1'b1 && n < 60);
		cmp(32'(n), 32'h18);
		axi_rd(OFS_CTRL, d, r);
		cmp(d, 32'h3);
	endtask

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		fifo_bypass_n = 1'b0;
		encoder_bypass = 1'b0;
		char_width_select = 1'b1;
		tx_fifo_reset = 1'b0;
		tx_halt_input = 1'b0;
		{want_load, want_special, want_viol, want_data, want_cmd} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_enc8();
		t_fill8();
		t_ignore();
		t_enc10();
		t_rate();
		summarize();
	end
endmodule

// ### sim/ste_encoder_asserts.sv
`timescale 1ns/100ps
module ste_encoder_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic        char_strobe,
	input wire logic        reference_clock,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// one clock domain, so one clocking and one reset for all
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// capture mark is a single cycle per character
	AST_STROBE_PULSE: assert property (char_strobe |=> !char_strobe)
		else $error("char strobe wider than one cycle");
	// a slot holds ten bits at least, one bit per clock or slower
	AST_STROBE_MIN_GAP: assert property (char_strobe |=> !char_strobe [*8])
		else $error("characters captured too close together");
	// slots follow back to back, at most 24 clocks apart; a frozen clock enable is excused
	AST_STROBE_MAX_GAP: assert property (disable iff (!aresetn || !ce) char_strobe |=> ##[8:23] char_strobe)
		else $error("character capture missing");
	// character clock rises only with a capture
	AST_REFERENCE_CLOCK_RISE: assert property ($rose(reference_clock) |-> char_strobe)
		else $error("character clock rose without capture");
	// and every capture raises it
	AST_REFERENCE_CLOCK_PER_CHAR: assert property (char_strobe |-> $rose(reference_clock))
		else $error("capture without character clock rise");
	// write response waits for the master
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	// read data waits for the master
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp))
		else $error("read data dropped early");
	// read answers in the next cycle
	AST_READ_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// joint address and data handshake answered within two edges
	AST_WRITE_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	// no second read accepted while one is pending
	AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answer pending");
endmodule

bind ste_encoder_top ste_encoder_asserts u_asserts (
	.aclk(aclk), .aresetn(aresetn), .ce(ce), .char_strobe(char_strobe), .reference_clock(reference_clock),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// ### sim/ste_host_model.sv
`timescale 1ns/100ps
module ste_host_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       char_strobe,
	input  wire logic       want_load,
	input  wire logic       want_special,
	input  wire logic       want_viol,
	input  wire logic [9:0] want_data,
	input  wire logic [7:0] want_cmd,
	output logic            tx_load_enable,
	output logic [9:0]      tx_data_bus,
	output logic [7:0]      tx_command_bus,
	output logic            tx_special_select,
	output logic            tx_violation_send
);
	// host logic: puts the next character up right after each capture and
	// holds it for the whole slot, so the next capture edge sees it settled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_load_enable    <= 1'b0;
			tx_data_bus       <= 10'h000;
			tx_command_bus    <= 8'h00;
			tx_special_select <= 1'b0;
			tx_violation_send <= 1'b0;
		end else if (char_strobe) begin
			tx_load_enable    <= want_load;
			tx_data_bus       <= want_data;
			tx_command_bus    <= want_cmd;
			tx_special_select <= want_special;
			tx_violation_send <= want_viol;
		end
	end
endmodule

// ### verilog/ste_encoder_top.sv
`timescale 1ns/100ps
module ste_encoder_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// mode and control pins, asynchronous to aclk
	input  wire logic              fifo_bypass_n,
	input  wire logic              encoder_bypass,
	input  wire logic              char_width_select,
	input  wire logic              tx_fifo_reset,
	input  wire logic              tx_halt_input,
	// host character port, same clock
	input  wire logic              tx_load_enable,
	input  wire logic [9:0]        tx_data_bus,
	input  wire logic [7:0]        tx_command_bus,
	input  wire logic              tx_special_select,
	input  wire logic              tx_violation_send,
	// line and character timing
	output logic                   serial_out,
	output logic                   reference_clock,
	output logic                   char_strobe,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	import ste_pkg::*;

	// address decode shared by the write and read paths
	function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
		logic [7:0] a;
		a = 8'(addr);
		if (a == OFS_CTRL) reg_sel = SEL_CTRL;
		else if (a == OFS_STATUS) reg_sel = SEL_STATUS;
		else if (a == OFS_FILL) reg_sel = SEL_FILL;
		else reg_sel = SEL_NONE;
	endfunction

	// bit reversal for words that go out lsb first
	function automatic logic [SYM_W-1:0] rev12(input logic [SYM_W-1:0] w);
		logic [SYM_W-1:0] r;
		r = '0;
		for (int i = 0; i < SYM_W; i++) begin
			r[i] = w[SYM_W-1-i];
		end
		rev12 = r;
	endfunction

	// ---------------- pin synchronisers ----------------
	logic [4:0] pin_meta_q;   // first stage, read only by second stage
	logic [4:0] pin_sync_q;   // second stage, safe to use
	logic       async_mode;   // fifo path selected
	logic       bypass_mode;  // encoder bypassed
	logic       width_8b;     // 8-bit characters
	logic       fifo_rst_s;
	logic       halt_s;

	// two flops per pin, the pins come from outside the clock domain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
		end else if (ce) begin
			pin_meta_q <= {tx_halt_input, tx_fifo_reset, char_width_select, encoder_bypass, fifo_bypass_n};
			pin_sync_q <= pin_meta_q;
		end
	end

	// modes from the three mode pins, then the two fifo control pins
	assign async_mode  = pin_sync_q[0];
	assign bypass_mode = pin_sync_q[1];
	assign width_8b    = pin_sync_q[2];
	assign fifo_rst_s  = pin_sync_q[3];
	assign halt_s      = pin_sync_q[4];

	// ---------------- control registers ----------------
	logic [1:0]        ctrl_q;       // rate select and transmit enable
	logic [FILL_W-1:0] fill_cnt_q;   // sync fill characters sent
	logic [FILL_W-1:0] fill_cnt_d;
	logic              last_fill_q;  // last loaded character was fill
	logic              rate_x5;
	logic              tx_enable;

	assign rate_x5   = ctrl_q[CTRL_RATE_BIT];
	assign tx_enable = ctrl_q[CTRL_EN_BIT];

	// ---------------- bit timing ----------------
	logic div_q;     // alternates when running at one bit per aclk pair
	logic bit_tick;  // one serial bit per tick

	// x10 gives a bit every aclk, x5 one every second aclk
	assign bit_tick = !rate_x5 | div_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 1'b0;
		end else if (ce) begin
			div_q <= rate_x5 ? !div_q : 1'b0;
		end
	end

	// ---------------- input register ----------------
	logic       load;          // character slot edge from the shifter
	logic [3:0] bit_cnt;
	logic       line;
	logic [9:0] cap_data_q;    // captured character
	logic [7:0] cap_cmd_q;
	logic       cap_sc_q;
	logic       cap_viol_q;
	logic       cap_fill_q;    // send sync pair instead of host data
	logic       cap_w8_q;      // width the character was taken in
	logic       cap_byp_q;     // bypass state at capture
	logic       hold_fill;     // async-only stop conditions
	logic       want_fill;

	// reset and halt only count on the fifo path; synchronous modes ignore them
	assign hold_fill = async_mode & (fifo_rst_s | halt_s);
	// idle host means sync fill in the next slot
	assign want_fill = !tx_load_enable | !tx_enable | hold_fill;

	// one character taken per slot edge, straight to the encoder, no fifo
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_data_q <= 10'h000;
			cap_cmd_q  <= 8'h00;
			cap_sc_q   <= 1'b0;
			cap_viol_q <= 1'b0;
			cap_fill_q <= 1'b1;
			cap_w8_q   <= 1'b1;
			cap_byp_q  <= 1'b0;
		end else if (ce && load) begin
			cap_data_q <= tx_data_bus;
			cap_cmd_q  <= tx_command_bus;
			cap_sc_q   <= tx_special_select;
			cap_viol_q <= tx_violation_send;
			cap_fill_q <= want_fill;
			cap_w8_q   <= width_8b;
			cap_byp_q  <= bypass_mode;
		end
	end

	// ---------------- encoder ----------------
	logic [SYM_W-1:0] data8_word;   // two 5-bit symbols
	logic [SYM_W-1:0] data10_word;  // two 6-bit symbols
	logic [SYM_W-1:0] cmd8_word;
	logic [SYM_W-1:0] cmd10_word;
	logic [SYM_W-1:0] fill_word;
	logic [SYM_W-1:0] viol_word;
	logic [SYM_W-1:0] raw_word;     // pre-encoded passthrough
	logic [SYM_W-1:0] enc_word;
	logic [SYM_W-1:0] tx_word;
	logic [3:0]       code8;
	logic [1:0]       code10;
	logic [4:0]       low10;

	// command code: four low bits, or bit 7 followed by bit 0
	assign code8  = cap_cmd_q[3:0];
	assign code10 = {cap_cmd_q[7], cap_cmd_q[0]};
	assign low10  = {cap_data_q[9], cap_data_q[3:0]};

	// data tables: high nibble or group first, left aligned
	assign data8_word  = {SYM5[cap_data_q[7:4]], SYM5[cap_data_q[3:0]], 2'b00};
	assign data10_word = {SYM6[cap_data_q[8:4]], SYM6[low10]};
	// fixed command pairs
	assign cmd8_word   = {CMD8[code8], 2'b00};
	assign cmd10_word  = CMD10[code10];
	// sync pair of the active width
	assign fill_word   = cap_w8_q ? {CMD8[CMD_SYNC], 2'b00} : CMD10[CMD_SYNC[1:0]];
	assign viol_word   = cap_w8_q ? {VIOL_SYM5, VIOL_SYM5, 2'b00} : {VIOL_SYM6, VIOL_SYM6};
	// bypass sends the raw character lsb first, special select unused
	assign raw_word    = cap_w8_q ? rev12({2'b00, cap_data_q}) : rev12({cap_cmd_q[7], cap_cmd_q[0], cap_data_q});
	// special select chooses command set over data set
	assign enc_word    = cap_sc_q ? (cap_w8_q ? cmd8_word : cmd10_word)
	                              : (cap_w8_q ? data8_word : data10_word);
	assign tx_word     = cap_fill_q ? fill_word
	                   : cap_byp_q  ? raw_word
	                   : cap_viol_q ? viol_word
	                   : enc_word;

	// ---------------- serializer ----------------
	ste_shifter u_shifter (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.bit_tick (bit_tick),
		.word     (tx_word),
		.len12    (!cap_w8_q),
		.load     (load),
		.bit_cnt  (bit_cnt),
		.line     (line)
	);

	// ---------------- timing outputs ----------------
	logic       ref_q;       // character clock, high in the first half of a slot
	logic       strobe_q;    // one cycle after each capture
	logic [3:0] half_cnt;

	assign half_cnt = cap_w8_q ? (CHAR_BITS_8B >> 1) : (CHAR_BITS_10B >> 1);
	assign serial_out      = line;
	assign reference_clock = ref_q;
	assign char_strobe     = strobe_q;

	// reference clock rises at each slot edge, serial bits locked to it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_q    <= 1'b0;
			strobe_q <= 1'b0;
		end else if (ce) begin
			ref_q    <= load | (ref_q & (bit_cnt > half_cnt));
			strobe_q <= load;
		end
	end

	// ---------------- axi write path ----------------
	logic              aw_have_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_have_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              aw_hs;
	logic              w_hs;
	logic              do_write;
	logic              aw_have_d;
	logic              w_have_d;
	logic              bvalid_d;
	logic [1:0]        wsel;
	logic              fill_clr;
	logic              fill_inc;

	assign aw_hs     = s_axi_awvalid & awready_q;
	assign w_hs      = s_axi_wvalid & wready_q;
	assign do_write  = aw_have_q & w_have_q & !bvalid_q;
	assign aw_have_d = (aw_have_q | aw_hs) & !do_write;
	assign w_have_d  = (w_have_q | w_hs) & !do_write;
	assign bvalid_d  = (bvalid_q & !s_axi_bready) | do_write;
	assign wsel      = reg_sel(aw_addr_q);
	assign fill_clr  = do_write & (wsel == SEL_FILL);
	assign fill_inc  = ce & load & cap_fill_q;
	// a clear and a count in the same cycle leave one fill counted
	assign fill_cnt_d = fill_clr ? FILL_W'(fill_inc) : fill_cnt_q + FILL_W'(fill_inc);

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// address and data taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_have_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else if (ce) begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= !aw_have_d & !bvalid_d;
			wready_q  <= !w_have_d & !bvalid_d;
			bvalid_q  <= bvalid_d;
			if (aw_hs) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// register contents; status is read only and ignores writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q      <= CTRL_RST;
			fill_cnt_q  <= '0;
			last_fill_q <= 1'b0;
		end else if (ce) begin
			if (do_write && wsel == SEL_CTRL && w_strb_q[0]) begin
				ctrl_q <= w_data_q[1:0];
			end
			fill_cnt_q <= fill_cnt_d;
			if (load) begin
				last_fill_q <= cap_fill_q;
			end
		end
	end

	// ---------------- axi read path ----------------
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        ar_hs;
	logic        rvalid_d;
	logic [1:0]  rsel;
	logic [31:0] status_word;
	logic [31:0] read_word;

	assign ar_hs       = s_axi_arvalid & arready_q;
	assign rvalid_d    = (rvalid_q & !s_axi_rready) | ar_hs;
	assign rsel        = reg_sel(s_axi_araddr);
	assign status_word = {28'h0000000, last_fill_q, width_8b, async_mode, bypass_mode};
	assign read_word   = (rsel == SEL_CTRL)   ? {30'h00000000, ctrl_q}
	                   : (rsel == SEL_STATUS) ? status_word
	                   : (rsel == SEL_FILL)   ? {16'h0000, fill_cnt_q}
	                   : 32'h00000000;

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// one read in flight, data latched at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= RESP_OKAY;
		end else if (ce) begin
			arready_q <= !rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_hs) begin
				rdata_q <= read_word;
				rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end
endmodule

// ### verilog/ste_pkg.sv
package ste_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FILL   = 8'h08;
	// register selector codes
	localparam logic [1:0] SEL_CTRL   = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_FILL   = 2'h2;
	localparam logic [1:0] SEL_NONE   = 2'h3;
	// control fields and reset value
	localparam int          CTRL_RATE_BIT = 0;
	localparam int          CTRL_EN_BIT   = 1;
	localparam logic [1:0]  CTRL_RST      = 2'h2;
	localparam int          FILL_W        = 16;
	// axi responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// serial framing
	localparam int          SYM_W          = 12;
	localparam logic [3:0]  CHAR_BITS_8B   = 4'hA;
	localparam logic [3:0]  CHAR_BITS_10B  = 4'hC;
	localparam logic [3:0]  CMD_SYNC       = 4'h0;
	// violation symbols, outside every code table
	localparam logic [4:0]  VIOL_SYM5 = 5'h01;
	localparam logic [5:0]  VIOL_SYM6 = 6'h01;
	// 4-bit nibble to 5-bit symbol
	localparam logic [4:0] SYM5 [0:15] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	// 5-bit group to 6-bit symbol
	localparam logic [5:0] SYM6 [0:31] = '{6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
		6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
		6'h3E, 6'h19, 6'h29, 6'h2D, 6'h1A, 6'h1B, 6'h1E, 6'h1F,
		6'h2A, 6'h2B, 6'h2E, 6'h2F, 6'h3A, 6'h3B, 6'h3C, 6'h3D};
	// 8-bit width command pairs, high symbol in bits 9..5
	localparam logic [9:0] CMD8 [0:15] = '{10'h311, 10'h3FF, 10'h1AD, 10'h1B9, 10'h3E4, 10'h1A7, 10'h327,
		10'h339, 10'h084, 10'h09F, 10'h080, 10'h0E7, 10'h0F9, 10'h004, 10'h01F, 10'h000};
	// 10-bit width command pairs, high symbol in bits 11..6
	localparam logic [11:0] CMD10 [0:3] = '{12'h623, 12'hFFF, 12'h75D, 12'h779};
endpackage

// ### verilog/ste_shifter.sv
`timescale 1ns/100ps
module ste_shifter (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      ce,
	input  wire logic                      bit_tick,
	input  wire logic [ste_pkg::SYM_W-1:0] word,
	input  wire logic                      len12,
	output logic                           load,
	output logic [3:0]                     bit_cnt,
	output logic                           line
);
	import ste_pkg::*;

	logic [SYM_W-1:0] shift_q;   // left-aligned symbols still to send
	logic [SYM_W-1:0] shift_d;
	logic [3:0]       cnt_q;     // bits left after the current one
	logic [3:0]       cnt_d;
	logic             line_q;    // nrzi line level
	logic             line_d;
	logic             next_bit;  // nrz bit going out this tick
	logic [3:0]       char_len;

	// a new word is taken exactly when the last bit of the old one has gone
	assign load     = bit_tick & (cnt_q == 4'h0);
	assign char_len = len12 ? CHAR_BITS_10B : CHAR_BITS_8B;
	// msb leaves first, so high-order symbol precedes low-order one
	assign next_bit = load ? word[SYM_W-1] : shift_q[SYM_W-1];
	assign shift_d  = load ? {word[SYM_W-2:0], 1'b0} : {shift_q[SYM_W-2:0], 1'b0};
	assign cnt_d    = load ? char_len - 4'h1 : cnt_q - 4'h1;
	// a one flips the line, a zero leaves it
	assign line_d   = line_q ^ next_bit;

	assign bit_cnt = cnt_q;
	assign line    = line_q;

	// shift on each bit tick only, so the x5 rate simply stretches bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= '0;
			cnt_q   <= 4'h0;
			line_q  <= 1'b0;
		end else if (ce && bit_tick) begin
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			line_q  <= line_d;
		end
	end
endmodule
